// [verilog/opaddr_pkg.sv]
// Package with constants and types for the operand-addressing front end.
`default_nettype none
package opaddr_pkg;
	// ----------------------------------------------------------------
	// Address windows
	// ----------------------------------------------------------------
	localparam logic [15:0] SHORT_LO   = 16'hFE20;
	localparam logic [15:0] SHORT_HI   = 16'hFF1F;
	localparam logic [15:0] SFR_LO     = 16'hFF00;
	localparam logic [15:0] SFR_HOLE_LO = 16'hFFD0;
	localparam logic [15:0] SFR_HOLE_HI = 16'hFFDF;
	localparam logic [15:0] CALLF_BASE = 16'h0800;
	localparam logic [15:0] CALLT_BASE = 16'h0040;
	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_FIELD   = 4'h1;
	localparam logic [3:0] REG_OPLO    = 4'h2;
	localparam logic [3:0] REG_OPHI    = 4'h3;
	localparam logic [3:0] REG_PCLO    = 4'h4;
	localparam logic [3:0] REG_PCHI    = 4'h5;
	localparam logic [3:0] REG_STATUS_WORD = 4'h6;
	localparam logic [3:0] REG_FLAGCMD = 4'h7;
	localparam logic [3:0] REG_SFRW    = 4'h8;
	localparam logic [3:0] REG_ADDRLO  = 4'h9;
	localparam logic [3:0] REG_ADDRHI  = 4'hA;
	localparam logic [3:0] REG_STATUS  = 4'hB;
	localparam logic [3:0] REG_REGNUM  = 4'hC;
	localparam logic [3:0] REG_IMMLO   = 4'hD;
	localparam logic [3:0] REG_IMMHI   = 4'hE;
	localparam logic [7:0] STATUS_WORD_RESET = 8'h02;
	// Status word bit positions.
	localparam int CARRY_POS     = 0;
	localparam int BANK_LO_POS   = 3;
	localparam int AUX_CARRY_POS = 4;
	localparam int BANK_HI_POS   = 5;
	localparam int ZERO_POS      = 6;
	localparam int INT_EN_POS    = 7;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_REG8, MODE_REGPAIR, MODE_SHORT8, MODE_SHORT16, MODE_SFR8, MODE_SFR16,
		MODE_ABS8, MODE_ABS16, MODE_CALLF, MODE_CALLT, MODE_REL, MODE_BIT,
		MODE_IMM8, MODE_IMM16
	} mode_t;
	typedef enum logic [2:0] {
		FLAG_KEEP, FLAG_CLEAR, FLAG_SET, FLAG_RESULT, FLAG_RESTORE
	} flag_op_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [4:0]  reg_num;
		logic [15:0] imm;
		logic [2:0]  bit_sel;
		logic        valid;
		logic        misaligned;
	} resolve_t;
	typedef struct packed {
		flag_op_t zero;
		flag_op_t aux_carry;
		flag_op_t carry;
	} flag_cmd_t;
endpackage : opaddr_pkg
`default_nettype wire

// [verilog/operand_resolver.sv]
// Combinational resolver from operand fields to absolute numbers and addresses.
`timescale 1ns/1ps
`default_nettype none
module operand_resolver (
	input  wire opaddr_pkg::mode_t mode,
	input  wire logic [15:0]       operand,
	input  wire logic [7:0]        field,
	input  wire logic [15:0]       pc,
	input  wire logic [1:0]        bank,
	input  wire logic              sfr_word_ok,
	output opaddr_pkg::resolve_t   res
);
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	logic [15:0] short_addr;
	logic [15:0] sfr_addr;

	// Short and SFR forms carry only the low byte; SFR uses page FFH, short picks FEH or FFH from that byte.
	assign short_addr = (operand[7:0] >= 8'h20) ? {8'hFE, operand[7:0]} : {8'hFF, operand[7:0]};
	assign sfr_addr   = {8'hFF, operand[7:0]};

	always_comb begin
		res = '0;
		res.valid = 1'b1;
		case (mode)
			opaddr_pkg::MODE_REG8: begin
				res.reg_num = {bank, field[2:0]}; // [RULE_01] [RULE_12] [RULE_14]
			end
			opaddr_pkg::MODE_REGPAIR: begin
				res.reg_num = {bank, field[1:0], 1'b0}; // [RULE_02] [RULE_14]
			end
			opaddr_pkg::MODE_SHORT8: begin
				res.addr  = short_addr;
				res.valid = in_range(short_addr, opaddr_pkg::SHORT_LO, opaddr_pkg::SHORT_HI); // [RULE_03]
			end
			opaddr_pkg::MODE_SHORT16: begin
				res.addr       = short_addr;
				res.misaligned = short_addr[0]; // [RULE_04] [RULE_16]
				res.valid      = in_range(short_addr, opaddr_pkg::SHORT_LO, opaddr_pkg::SHORT_HI) && !short_addr[0];
			end
			opaddr_pkg::MODE_SFR8: begin
				res.addr  = sfr_addr;
				res.valid = !in_range(sfr_addr, opaddr_pkg::SFR_HOLE_LO, opaddr_pkg::SFR_HOLE_HI); // [RULE_08]
			end
			opaddr_pkg::MODE_SFR16: begin
				res.addr       = sfr_addr;
				res.misaligned = sfr_addr[0]; // [RULE_09] [RULE_16]
				res.valid      = !in_range(sfr_addr, opaddr_pkg::SFR_HOLE_LO, opaddr_pkg::SFR_HOLE_HI)
					&& !sfr_addr[0] && sfr_word_ok; // [RULE_08] [RULE_09]
			end
			opaddr_pkg::MODE_ABS8: begin
				res.addr = operand; // [RULE_05]
			end
			opaddr_pkg::MODE_ABS16: begin
				res.addr       = operand;
				res.misaligned = operand[0]; // [RULE_05] [RULE_16]
				res.valid      = !operand[0];
			end
			opaddr_pkg::MODE_CALLF: begin
				res.addr = opaddr_pkg::CALLF_BASE | {5'h00, operand[10:0]}; // [RULE_06]
			end
			opaddr_pkg::MODE_CALLT: begin
				res.addr = opaddr_pkg::CALLT_BASE | {10'h000, operand[4:0], 1'b0}; // [RULE_07]
			end
			opaddr_pkg::MODE_REL: begin
				res.addr = pc + {{8{operand[7]}}, operand[7:0]}; // [RULE_13]
			end
			opaddr_pkg::MODE_BIT: begin
				res.bit_sel = field[2:0]; // [RULE_10]
			end
			opaddr_pkg::MODE_IMM8: begin
				res.imm = {8'h00, operand[7:0]}; // [RULE_11]
			end
			opaddr_pkg::MODE_IMM16: begin
				res.imm = operand; // [RULE_11]
			end
			default: begin
				res.valid = 1'b0;
			end
		endcase
	end
endmodule : operand_resolver
`default_nettype wire

// [verilog/flag_updater.sv]
// Applies per-flag update codes to the program status word.
`timescale 1ns/1ps
`default_nettype none
module flag_updater (
	input  wire logic [7:0]            status_in,
	input  wire opaddr_pkg::flag_cmd_t cmd,
	input  wire logic [2:0]            result,
	input  wire logic [2:0]            saved,
	output logic [7:0]                 status_out
);
	function automatic logic apply(input opaddr_pkg::flag_op_t op, input logic cur, input logic r, input logic s);
		case (op)
			opaddr_pkg::FLAG_CLEAR:   apply = 1'b0;
			opaddr_pkg::FLAG_SET:     apply = 1'b1;
			opaddr_pkg::FLAG_RESULT:  apply = r;
			opaddr_pkg::FLAG_RESTORE: apply = s;
			default:                  apply = cur;
		endcase
	endfunction : apply

	// Result and saved bits are ordered {zero, aux carry, carry}.
	always_comb begin
		status_out = status_in;
		status_out[opaddr_pkg::ZERO_POS]      = apply(cmd.zero, status_in[opaddr_pkg::ZERO_POS],
			result[2], saved[2]); // [RULE_15]
		status_out[opaddr_pkg::AUX_CARRY_POS] = apply(cmd.aux_carry, status_in[opaddr_pkg::AUX_CARRY_POS],
			result[1], saved[1]); // [RULE_15]
		status_out[opaddr_pkg::CARRY_POS]     = apply(cmd.carry, status_in[opaddr_pkg::CARRY_POS],
			result[0], saved[0]); // [RULE_15]
	end
endmodule : flag_updater
`default_nettype wire

// [verilog/cpu_operand_addressing.sv]
// Top of the operand-addressing front end with its register port.
//
// Summary of operation
// RULE_01 - Byte registers X,A,C,B,E,D,L,H are 0..7.
// RULE_02 - Pairs, word accumulator first, are numbered 0..3.
// RULE_03 - Short byte operand lies in FE20H..FF1FH.
// RULE_04 - Short word operand same window, even only.
// RULE_05 - Absolute operand full space; words even only.
// RULE_06 - Fixed call target lies in 0800H..0FFFH.
// RULE_07 - Call table entry even within 0040H..007FH.
// RULE_08 - SFR forms never reach FFD0H..FFDFH.
// RULE_09 - Word SFR needs even, word-capable register.
// RULE_10 - Bit position is a three-bit field.
// RULE_11 - Word immediate sixteen bits, byte eight.
// RULE_12 - Four banks chosen by status word bank field.
// RULE_13 - Relative displacement signed eight bits plus PC.
// RULE_14 - A is byte accumulator, pair zero word accumulator.
// RULE_15 - Each flag: keep, clear, set, result, restore.
// RULE_16 - Odd address on aligned word access is invalid.
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_addressing (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic [7:0]      RDATA,
	output logic            OPERAND_VALID,
	output logic            OPERAND_MISALIGNED
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]            mode;
		logic [7:0]            field;
		logic [15:0]           operand;
		logic [15:0]           pc;
		logic [7:0]            status_word;
		logic [7:0]            saved;
		logic                  sfr_word_ok;
		opaddr_pkg::flag_cmd_t flag_cmd;
		opaddr_pkg::resolve_t  res;
		logic [7:0]            rdata;
	} state_t;

	state_t            st;
	state_t            next_st;
	logic [1:0]        rst_sync;
	logic              rst_n;
	opaddr_pkg::resolve_t res_c;
	logic [7:0]        updated_status;

	// Reset is released synchronously so all state leaves reset on one edge.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ----------------------------------------------------------------
	// Resolution and flag datapath
	// ----------------------------------------------------------------
	operand_resolver u_resolver (
		.mode        (opaddr_pkg::mode_t'(st.mode)),
		.operand     (st.operand),
		.field       (st.field),
		.pc          (st.pc),
		.bank        ({st.status_word[opaddr_pkg::BANK_HI_POS],
			st.status_word[opaddr_pkg::BANK_LO_POS]}), // [RULE_12]
		.sfr_word_ok (st.sfr_word_ok),
		.res         (res_c)
	);

	flag_updater u_flags (
		.status_in  (st.status_word),
		.cmd        (st.flag_cmd),
		.result     (WDATA[2:0]),
		.saved      (st.saved[2:0]),
		.status_out (updated_status)
	);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Writing FLAGCMD applies the held update codes, with WDATA[2:0] as the {zero, aux carry, carry} result.
	always_comb begin
		next_st     = st;
		next_st.res = res_c;
		if (WR) begin
			case (ADDR)
				opaddr_pkg::REG_CTRL:    next_st.mode = WDATA[3:0];
				opaddr_pkg::REG_FIELD:   next_st.field = WDATA;
				opaddr_pkg::REG_OPLO:    next_st.operand[7:0] = WDATA;
				opaddr_pkg::REG_OPHI:    next_st.operand[15:8] = WDATA;
				opaddr_pkg::REG_PCLO:    next_st.pc[7:0] = WDATA;
				opaddr_pkg::REG_PCHI:    next_st.pc[15:8] = WDATA;
				opaddr_pkg::REG_STATUS_WORD: begin
					next_st.status_word = WDATA;
					next_st.saved       = {5'h00, WDATA[opaddr_pkg::ZERO_POS], WDATA[opaddr_pkg::AUX_CARRY_POS],
						WDATA[opaddr_pkg::CARRY_POS]};
				end
				opaddr_pkg::REG_FLAGCMD: begin
					next_st.status_word = updated_status; // [RULE_15]
				end
				opaddr_pkg::REG_SFRW:    next_st.sfr_word_ok = WDATA[0];
				default: begin
				end
			endcase
		end
		// Each update code rides in spare upper bits of CTRL, FIELD or SFRW; codes above four mean keep.
		if (WR && ADDR == opaddr_pkg::REG_CTRL) begin
			next_st.flag_cmd.zero = opaddr_pkg::flag_op_t'(WDATA[6:4] > 3'h4 ? 3'h0 : WDATA[6:4]); // [RULE_15]
		end
		if (WR && ADDR == opaddr_pkg::REG_FIELD) begin
			next_st.flag_cmd.aux_carry = opaddr_pkg::flag_op_t'(WDATA[7:5] > 3'h4 ? 3'h0 : WDATA[7:5]); // [RULE_15]
		end
		if (WR && ADDR == opaddr_pkg::REG_SFRW) begin
			next_st.flag_cmd.carry = opaddr_pkg::flag_op_t'(WDATA[7:5] > 3'h4 ? 3'h0 : WDATA[7:5]); // [RULE_15]
		end
		next_st.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				opaddr_pkg::REG_CTRL:    next_st.rdata = {1'b0, st.flag_cmd.zero, st.mode};
				opaddr_pkg::REG_FIELD:   next_st.rdata = st.field;
				opaddr_pkg::REG_OPLO:    next_st.rdata = st.operand[7:0];
				opaddr_pkg::REG_OPHI:    next_st.rdata = st.operand[15:8];
				opaddr_pkg::REG_PCLO:    next_st.rdata = st.pc[7:0];
				opaddr_pkg::REG_PCHI:    next_st.rdata = st.pc[15:8];
				opaddr_pkg::REG_STATUS_WORD: next_st.rdata = st.status_word;
				opaddr_pkg::REG_SFRW:    next_st.rdata = {st.flag_cmd.carry, 4'h0, st.sfr_word_ok};
				opaddr_pkg::REG_ADDRLO:  next_st.rdata = st.res.addr[7:0];
				opaddr_pkg::REG_ADDRHI:  next_st.rdata = st.res.addr[15:8];
				opaddr_pkg::REG_STATUS:  next_st.rdata = {3'h0, st.res.bit_sel, st.res.misaligned, st.res.valid};
				opaddr_pkg::REG_REGNUM:  next_st.rdata = {3'h0, st.res.reg_num};
				opaddr_pkg::REG_IMMLO:   next_st.rdata = st.res.imm[7:0];
				opaddr_pkg::REG_IMMHI:   next_st.rdata = st.res.imm[15:8];
				default:                 next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st     <= '0;
			st.status_word <= opaddr_pkg::STATUS_WORD_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA              = st.rdata;
	assign OPERAND_VALID      = st.res.valid;
	assign OPERAND_MISALIGNED = st.res.misaligned;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_REG8_NUM: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_01]
		st.mode == 4'(opaddr_pkg::MODE_REG8) |-> res_c.reg_num[2:0] == st.field[2:0])
		else $error("byte register number wrong");
	AST_PAIR_NUM: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_02]
		st.mode == 4'(opaddr_pkg::MODE_REGPAIR) |-> res_c.reg_num[2:0] == {st.field[1:0], 1'b0})
		else $error("register pair number wrong");
	AST_SHORT_WIN: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_03]
		st.mode == 4'(opaddr_pkg::MODE_SHORT8) && res_c.valid |->
		res_c.addr >= 16'hFE20 && res_c.addr <= 16'hFF1F)
		else $error("short address outside window");
	AST_SHORT_EVEN: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_04]
		st.mode == 4'(opaddr_pkg::MODE_SHORT16) && res_c.valid |-> !res_c.addr[0])
		else $error("short word address odd");
	AST_ABS_ODD: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_16]
		st.mode == 4'(opaddr_pkg::MODE_ABS16) && st.operand[0] && !WR |=> OPERAND_MISALIGNED && !OPERAND_VALID)
		else $error("odd word address not flagged");
	AST_CALLF_WIN: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_06]
		st.mode == 4'(opaddr_pkg::MODE_CALLF) |-> res_c.addr >= 16'h0800 && res_c.addr <= 16'h0FFF)
		else $error("fixed call target outside region");
	AST_CALLT_WIN: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_07]
		st.mode == 4'(opaddr_pkg::MODE_CALLT) |->
		res_c.addr >= 16'h0040 && res_c.addr <= 16'h007F && !res_c.addr[0])
		else $error("call table entry wrong");
	AST_SFR_HOLE: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_08]
		(st.mode == 4'(opaddr_pkg::MODE_SFR8) || st.mode == 4'(opaddr_pkg::MODE_SFR16)) && res_c.valid |->
		!(res_c.addr >= 16'hFFD0 && res_c.addr <= 16'hFFDF))
		else $error("sfr form reached reserved range");
	AST_REL_ADD: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_13]
		st.mode == 4'(opaddr_pkg::MODE_REL) |-> res_c.addr == 16'(st.pc + {{8{st.operand[7]}}, st.operand[7:0]}))
		else $error("relative target wrong");
	AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_15]
		WR && ADDR == opaddr_pkg::REG_FLAGCMD && st.flag_cmd.carry == opaddr_pkg::FLAG_SET
		|=> st.status_word[opaddr_pkg::CARRY_POS])
		else $error("carry not set");
endmodule : cpu_operand_addressing
`default_nettype wire

// [sim/opaddr_prog_mem.sv]
// Program memory model that supplies operand bytes from an instruction stream.
`timescale 1ns/1ps
`default_nettype none
module opaddr_prog_mem (
	input  wire logic       clk,
	input  wire logic [7:0] fetch_addr,
	output logic [7:0]      fetch_data
);
	// ----------------------------------------------------------------
	// Operand store
	// ----------------------------------------------------------------
	// Words sit low byte first; a fetch answers one cycle later, like a synchronous ROM.
	localparam logic [15:0] WORDS [0:15] = '{16'h0020, 16'h001F, 16'h0021, 16'h0022, 16'h00D0, 16'h00CF,
		16'h00E0, 16'h00DE, 16'hFFFF, 16'h1235, 16'h0000, 16'h07FF, 16'h0080, 16'h007F, 16'h12A5, 16'h00E1};
	always_ff @(posedge clk) begin
		fetch_data <= fetch_addr[0] ? WORDS[fetch_addr[4:1]][15:8] : WORDS[fetch_addr[4:1]][7:0];
	end
endmodule : opaddr_prog_mem
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the operand-addressing front end.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk;
	logic       reset_n;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       op_valid;
	logic       op_mis;
	logic [7:0] fa;
	logic [7:0] fd;
	int         n_errors;
	int         tests_run;
	logic [7:0] d;
	logic [15:0] w;

	cpu_operand_addressing u_dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .OPERAND_VALID(op_valid), .OPERAND_MISALIGNED(op_mis));
	opaddr_prog_mem u_mem (.clk(clk), .fetch_addr(fa), .fetch_data(fd));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wrr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wrr

	task automatic rdr(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rdr

	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		repeat (2) @(posedge clk);
		rdr(a, lo);
		rdr(a + 4'h1, hi);
		v = {hi, lo};
	endtask : rd16

	// Operand bytes come from the program memory, low byte first.
	task automatic load(input int k, input opaddr_pkg::mode_t m, input logic [7:0] fld, input logic [15:0] pc,
		input logic ok);
		logic [7:0] lo;
		@(posedge clk);
		fa <= 8'(2 * k);
		@(posedge clk);
		fa <= 8'(2 * k + 1);
		@(negedge clk);
		lo = fd;
		@(negedge clk);
		wrr(opaddr_pkg::REG_OPLO, lo);
		wrr(opaddr_pkg::REG_OPHI, fd);
		wrr(opaddr_pkg::REG_FIELD, fld);
		wrr(opaddr_pkg::REG_PCLO, pc[7:0]);
		wrr(opaddr_pkg::REG_PCHI, pc[15:8]);
		wrr(opaddr_pkg::REG_SFRW, {7'h00, ok});
		wrr(opaddr_pkg::REG_CTRL, {4'h0, m});
	endtask : load

	task automatic op(input int k, input opaddr_pkg::mode_t m, input logic [15:0] pc, input logic ok,
		input logic [15:0] ea, input logic ev, input logic em);
		load(k, m, 8'h00, pc, ok);
		rd16(opaddr_pkg::REG_ADDRLO, w);
		chk("addr", w, ea);
		rdr(opaddr_pkg::REG_STATUS, d);
		chk("status", {14'h0, d[1:0]}, {14'h0, em, ev});
		chk("pins", {14'h0, op_mis, op_valid}, {14'h0, em, ev});
	endtask : op

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		tests_run = 0;
		reset_n = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		fa = 8'h00;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdr(opaddr_pkg::REG_STATUS_WORD, d);
		chk("status word reset", {8'h00, d}, 16'h0002);
		wrr(4'hF, 8'h5A);
		rdr(4'hF, d);
		chk("unmapped", {8'h00, d}, 16'h0000);
		for (int b = 0; b < 4; b++) begin
			wrr(opaddr_pkg::REG_STATUS_WORD, {2'b00, 1'(b >> 1), 1'b0, 1'(b), 3'b000});
			for (int i = 0; i < 8; i++) begin
				wrr(opaddr_pkg::REG_FIELD, 8'(i));
				wrr(opaddr_pkg::REG_CTRL, {4'h0, opaddr_pkg::MODE_REG8});
				repeat (2) @(posedge clk);
				rdr(opaddr_pkg::REG_REGNUM, d);
				chk("reg8 number", {11'h0, d[4:0]}, {11'h0, 2'(b), 3'(i)});
				if (i < 4) begin
					wrr(opaddr_pkg::REG_CTRL, {4'h0, opaddr_pkg::MODE_REGPAIR});
					repeat (2) @(posedge clk);
					rdr(opaddr_pkg::REG_REGNUM, d);
					chk("pair number", {11'h0, d[4:0]}, {11'h0, 2'(b), 2'(i), 1'b0});
				end
			end
		end
		op(0, opaddr_pkg::MODE_SHORT8, 16'h0000, 1'b0, 16'hFE20, 1'b1, 1'b0);
		op(1, opaddr_pkg::MODE_SHORT8, 16'h0000, 1'b0, 16'hFF1F, 1'b1, 1'b0);
		op(2, opaddr_pkg::MODE_SHORT16, 16'h0000, 1'b0, 16'hFE21, 1'b0, 1'b1);
		op(3, opaddr_pkg::MODE_SHORT16, 16'h0000, 1'b0, 16'hFE22, 1'b1, 1'b0);
		op(4, opaddr_pkg::MODE_SFR8, 16'h0000, 1'b0, 16'hFFD0, 1'b0, 1'b0);
		op(5, opaddr_pkg::MODE_SFR8, 16'h0000, 1'b0, 16'hFFCF, 1'b1, 1'b0);
		op(6, opaddr_pkg::MODE_SFR16, 16'h0000, 1'b1, 16'hFFE0, 1'b1, 1'b0);
		op(6, opaddr_pkg::MODE_SFR16, 16'h0000, 1'b0, 16'hFFE0, 1'b0, 1'b0);
		op(7, opaddr_pkg::MODE_SFR16, 16'h0000, 1'b1, 16'hFFDE, 1'b0, 1'b0);
		op(15, opaddr_pkg::MODE_SFR16, 16'h0000, 1'b1, 16'hFFE1, 1'b0, 1'b1);
		op(8, opaddr_pkg::MODE_ABS8, 16'h0000, 1'b0, 16'hFFFF, 1'b1, 1'b0);
		op(9, opaddr_pkg::MODE_ABS16, 16'h0000, 1'b0, 16'h1235, 1'b0, 1'b1);
		op(10, opaddr_pkg::MODE_ABS16, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0);
		op(11, opaddr_pkg::MODE_CALLF, 16'h0000, 1'b0, 16'h0FFF, 1'b1, 1'b0);
		op(1, opaddr_pkg::MODE_CALLT, 16'h0000, 1'b0, 16'h007E, 1'b1, 1'b0);
		op(12, opaddr_pkg::MODE_REL, 16'h1000, 1'b0, 16'h0F80, 1'b1, 1'b0);
		op(13, opaddr_pkg::MODE_REL, 16'hFFF0, 1'b0, 16'h006F, 1'b1, 1'b0);
		load(14, opaddr_pkg::MODE_IMM8, 8'h00, 16'h0000, 1'b0);
		rd16(opaddr_pkg::REG_IMMLO, w);
		chk("imm8", w, 16'h00A5);
		load(14, opaddr_pkg::MODE_IMM16, 8'h00, 16'h0000, 1'b0);
		rd16(opaddr_pkg::REG_IMMLO, w);
		chk("imm16", w, 16'h12A5);
		load(0, opaddr_pkg::MODE_BIT, 8'hFD, 16'h0000, 1'b0);
		repeat (2) @(posedge clk);
		rdr(opaddr_pkg::REG_STATUS, d);
		chk("bit select", {13'h0, d[4:2]}, 16'h0005);
		// Each code is tried from a state that differs from the saved copy, so restore is visible.
		// Code five is outside the defined set and must behave as keep.
		for (int c = 0; c < 6; c++) begin
			wrr(opaddr_pkg::REG_STATUS_WORD, 8'h41);
			wrr(opaddr_pkg::REG_CTRL, {1'b0, 3'h3, 4'h0});
			wrr(opaddr_pkg::REG_FIELD, {3'h3, 5'h00});
			wrr(opaddr_pkg::REG_SFRW, {3'h3, 5'h00});
			wrr(opaddr_pkg::REG_FLAGCMD, 8'h02);
			wrr(opaddr_pkg::REG_CTRL, {1'b0, 3'(c), 4'h0});
			wrr(opaddr_pkg::REG_FIELD, {3'(c), 5'h00});
			wrr(opaddr_pkg::REG_SFRW, {3'(c), 5'h00});
			wrr(opaddr_pkg::REG_FLAGCMD, 8'h06);
			repeat (2) @(posedge clk);
			rdr(opaddr_pkg::REG_STATUS_WORD, d);
			case (c)
				0: chk("flags keep", {8'h00, d}, 16'h0010);
				1: chk("flags clear", {8'h00, d}, 16'h0000);
				2: chk("flags set", {8'h00, d}, 16'h0051);
				3: chk("flags result", {8'h00, d}, 16'h0050);
				4: chk("flags restore", {8'h00, d}, 16'h0041);
				default: chk("flags unused code", {8'h00, d}, 16'h0010);
			endcase
		end
		results();
	end

	initial begin
		// The tests need about 1,000 cycles; this limit leaves a wide margin.
		#200us;
		n_errors++;
		results();
	end
endmodule : tb
`default_nettype wire
